// ---- include/vib_sup_pkg.sv ----
// Purpose: Shared constants and types for the vibration suppression session block
// Assumes: APB with 32-bit data, one clock pclk at 200 MHz
// Notes:   Offsets are byte addresses of aligned words
package vib_sup_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_FREQ_HZ      = 200_000_000;
    localparam int unsigned DONE_BLINK_MS    = 2000;
    localparam int unsigned TIMEOUT_MS       = 10000;
    localparam int unsigned DONE_BLINK_CYCLES = CLK_FREQ_HZ / 1000 * DONE_BLINK_MS;
    localparam int unsigned TIMEOUT_CYCLES    = CLK_FREQ_HZ / 1000 * TIMEOUT_MS;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_STATUS    = 8'h04;
    localparam logic [7:0] ADDR_SET_FREQ  = 8'h08;
    localparam logic [7:0] ADDR_ACT_FREQ  = 8'h0C;
    localparam logic [7:0] ADDR_FREQ_A    = 8'h10;
    localparam logic [7:0] ADDR_FREQ_B    = 8'h14;
    localparam logic [7:0] ADDR_MF_SWITCH = 8'h18;
    localparam logic [7:0] ADDR_MF_GAIN   = 8'h1C;
    localparam logic [7:0] ADDR_MF_COMP   = 8'h20;
    localparam logic [7:0] ADDR_MF_BIAS_R = 8'h24;
    localparam logic [7:0] ADDR_SUP2_FREQ = 8'h28;
    localparam logic [7:0] ADDR_SUP2_COMP = 8'h2C;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h30;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h34;

    // Control command bits (write one to act)
    localparam int CMD_ENTER   = 0;
    localparam int CMD_CONFIRM = 1;
    localparam int CMD_SAVE    = 2;
    localparam int CMD_EXIT    = 3;
    localparam int CMD_ABORT   = 4;

    // Interrupt status bits
    localparam int IRQ_APPLIED = 0;
    localparam int IRQ_SAVED   = 1;
    localparam int IRQ_TIMEOUT = 2;
    localparam int IRQ_EXITED  = 3;
    localparam int IRQ_BITS    = 4;

    // Top digit of the model following switch, bits [15:12]
    localparam int MF_TOP_LSB = 12;
    localparam logic [3:0] MF_COMBINE = 4'h1;

    localparam logic [15:0] FREQ_A_RESET = 16'h01F4;
    localparam logic [15:0] MF_GAIN_RESET = 16'h01F4;
    localparam logic [15:0] MF_COMP_RESET = 16'h03E8;

    typedef enum logic [4:0] {
        ST_IDLE    = 5'b00001,
        ST_TUNE    = 5'b00010,
        ST_PENDING = 5'b00100,
        ST_APPLIED = 5'b01000,
        ST_ABORT   = 5'b10000
    } state_type;

    typedef struct packed {
        logic display_menu;
        logic display_run;
        logic done_blink;
        logic setting_blink;
        logic session_active;
    } display_type;

    typedef struct packed {
        logic        suppress_enable;
        logic [15:0] active_freq;
        logic        speed_ff_enable;
        logic        torque_ff_enable;
        logic        feedforward_gain_enable;
    } loop_cfg_type;

endpackage : vib_sup_pkg

// ---- hdl/vibration_suppression_setting_ctrl.sv ----
// Purpose: Vibration suppression tuning session controller behind an APB slave
// Assumes: Motor status inputs synchronous to pclk; operator keys arrive as APB writes
// Notes:   Session commands live in the control register as write-one pulses
//
// How it works
// - Confirm applies shown frequency, enables suppression
// - Save stores setting, blinks done two seconds
// - Exit ends session, shows function menu
// - No setting change while motor runs, except the shown frequency
// - Motor not stopped in 10 s reverts
// - New response takes effect at rest only
// - Feedforward paths disabled by default
// - Switch top digit combines external feedforward
// - Some parameters locked during session
// - Session end updates switch, gain, frequencies; here Exit changes none of them, and in a session only Save writes A and B
// - Entry loads shown frequency from stored A
// - Blink label when shown differs from used
// - Abort waits for stop, then reverts
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/10ps

module vibration_suppression_setting_ctrl
    import vib_sup_pkg::*;
#(
    parameter int unsigned TIMEOUT_COUNT = vib_sup_pkg::TIMEOUT_CYCLES,
    parameter int unsigned BLINK_COUNT   = vib_sup_pkg::DONE_BLINK_CYCLES
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      motor_running,
    input  wire logic                      reference_present,
    input  wire logic [15:0]               measured_freq,
    output vib_sup_pkg::display_type       display,
    output vib_sup_pkg::loop_cfg_type      loop_cfg,
    output logic                           irq
);
    import vib_sup_pkg::*;

    initial begin
        if (TIMEOUT_COUNT < 2 || BLINK_COUNT < 2) begin
            $error("Counts must be at least 2");
        end
    end

    // ************************************************************
    // APB access
    // ************************************************************
    logic wr_en;
    assign wr_en   = psel && penable && pwrite;
    assign pready  = 1'b1;

    logic [15:0] setting_freq;
    logic [15:0] applied_freq;
    logic [15:0] prior_freq;
    logic [15:0] freq_a;
    logic [15:0] freq_b;
    logic [15:0] mf_switch;
    logic [15:0] mf_gain;
    logic [15:0] mf_comp;
    logic [15:0] mf_bias_rev;
    logic [15:0] sup2_freq;
    logic [15:0] sup2_comp;
    logic [IRQ_BITS-1:0] irq_stat;
    logic [IRQ_BITS-1:0] irq_mask;
    logic [IRQ_BITS-1:0] irq_event;
    logic        timeout_err;
    logic        saved;
    state_type   state;
    logic [31:0] wait_count;
    logic [31:0] blink_count;

    logic cmd_enter;
    logic cmd_confirm;
    logic cmd_save;
    logic cmd_exit;
    logic cmd_abort;
    logic ctrl_wr;
    logic mapped;
    logic session;
    logic at_rest;
    logic timed_out;

    assign ctrl_wr     = wr_en && (paddr == ADDR_CTRL);
    assign cmd_enter   = ctrl_wr && pwdata[CMD_ENTER];
    assign cmd_confirm = ctrl_wr && pwdata[CMD_CONFIRM];
    assign cmd_save    = ctrl_wr && pwdata[CMD_SAVE];
    assign cmd_exit    = ctrl_wr && pwdata[CMD_EXIT];
    assign cmd_abort   = ctrl_wr && pwdata[CMD_ABORT];
    assign session     = (state != ST_IDLE);
    assign at_rest     = !motor_running && !reference_present;
    assign timed_out   = (state == ST_PENDING) && (wait_count >= TIMEOUT_COUNT - 1);

    // Map is contiguous and word aligned, so a range test decodes it
    always_comb begin
        if (paddr[1:0] == 2'h0 && paddr <= ADDR_IRQ_MASK) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    assign pslverr = psel && penable && !mapped;

    // ************************************************************
    // Session state machine
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (cmd_enter) begin
                        state <= ST_TUNE;
                    end
                end
                ST_TUNE, ST_APPLIED: begin
                    if (cmd_exit) begin
                        state <= ST_IDLE;
                    end else if (cmd_abort) begin
                        state <= ST_ABORT;
                    end else if (cmd_confirm) begin
                        state <= ST_PENDING;
                    end
                end
                ST_PENDING: begin
                    if (cmd_abort) begin
                        state <= ST_ABORT;
                    end else if (timed_out) begin
                        state <= ST_TUNE;
                    end else if (at_rest) begin
                        state <= ST_APPLIED;
                    end
                end
                ST_ABORT: begin
                    if (!motor_running) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Wait for the motor to stop after a change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_count <= 32'h0000_0000;
        end else if (state == ST_PENDING && motor_running) begin
            wait_count <= wait_count + 32'h0000_0001;
        end else begin
            wait_count <= 32'h0000_0000;
        end
    end

    // ************************************************************
    // Frequencies
    // ************************************************************
    // The prior copy lets a timeout or abort restore in one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setting_freq <= FREQ_A_RESET;
            applied_freq <= FREQ_A_RESET;
            prior_freq   <= FREQ_A_RESET;
        end else begin
            if (state == ST_IDLE && cmd_enter) begin
                setting_freq <= freq_a;
                applied_freq <= freq_a;
                prior_freq   <= freq_a;
            end else if ((state == ST_TUNE || state == ST_APPLIED) && cmd_confirm) begin
                applied_freq <= setting_freq;
            end else if (timed_out && !cmd_abort) begin
                applied_freq <= prior_freq;
            end else if (state == ST_ABORT && !motor_running) begin
                applied_freq <= prior_freq;
                setting_freq <= prior_freq;
            end else if (state == ST_APPLIED && cmd_save) begin
                prior_freq <= applied_freq;
            end else if (wr_en && paddr == ADDR_SET_FREQ && session && state != ST_ABORT) begin
                setting_freq <= pwdata[15:0];
            end else if (wr_en && paddr == ADDR_STATUS && session) begin
                setting_freq <= measured_freq;
            end
        end
    end

    // ************************************************************
    // Tuning parameters
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_a      <= FREQ_A_RESET;
            freq_b      <= FREQ_A_RESET;
            mf_switch   <= 16'h0000;
            mf_gain     <= MF_GAIN_RESET;
            mf_comp     <= MF_COMP_RESET;
            mf_bias_rev <= 16'h0000;
            sup2_freq   <= FREQ_A_RESET;
            sup2_comp   <= MF_COMP_RESET;
            saved       <= 1'b0;
        end else begin
            if (state == ST_APPLIED && cmd_save && !motor_running) begin
                freq_a <= applied_freq;
                freq_b <= applied_freq;
                saved  <= 1'b1;
            end else if (state == ST_IDLE) begin
                saved <= 1'b0;
            end
            if (wr_en && paddr == ADDR_MF_SWITCH && !motor_running) begin
                mf_switch <= pwdata[15:0];
            end
            if (wr_en && !session && !motor_running) begin
                if (paddr == ADDR_FREQ_A) begin
                    freq_a <= pwdata[15:0];
                end else if (paddr == ADDR_FREQ_B) begin
                    freq_b <= pwdata[15:0];
                end else if (paddr == ADDR_MF_GAIN) begin
                    mf_gain <= pwdata[15:0];
                end else if (paddr == ADDR_MF_COMP) begin
                    mf_comp <= pwdata[15:0];
                end else if (paddr == ADDR_MF_BIAS_R) begin
                    mf_bias_rev <= pwdata[15:0];
                end else if (paddr == ADDR_SUP2_FREQ) begin
                    sup2_freq <= pwdata[15:0];
                end else if (paddr == ADDR_SUP2_COMP) begin
                    sup2_comp <= pwdata[15:0];
                end
            end
        end
    end

    // ************************************************************
    // Done indication
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_count <= 32'h0000_0000;
        end else if (state == ST_APPLIED && cmd_save) begin
            blink_count <= BLINK_COUNT;
        end else if (blink_count != 32'h0000_0000) begin
            blink_count <= blink_count - 32'h0000_0001;
        end
    end

    // ************************************************************
    // Outputs to display and loop
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            display  <= '0;
            loop_cfg <= '0;
        end else begin
            display.session_active <= session;
            display.setting_blink  <= session && (setting_freq != applied_freq);
            display.done_blink     <= (blink_count != 32'h0000_0000);
            display.display_run    <= session && (blink_count == 32'h0000_0000);
            display.display_menu   <= !session;
            loop_cfg.feedforward_gain_enable <= 1'b0;
            loop_cfg.speed_ff_enable  <= (mf_switch[MF_TOP_LSB +: 4] == MF_COMBINE);
            loop_cfg.torque_ff_enable <= (mf_switch[MF_TOP_LSB +: 4] == MF_COMBINE);
            if (state == ST_PENDING && at_rest) begin
                loop_cfg.active_freq <= applied_freq;
            end else if (!session || (timed_out && !cmd_abort)) begin
                loop_cfg.active_freq <= prior_freq;
            end
            loop_cfg.suppress_enable <= session ? (state != ST_TUNE) : 1'b1;
        end
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    assign irq_event[IRQ_APPLIED] = (state == ST_PENDING) && at_rest && !timed_out;
    assign irq_event[IRQ_SAVED]   = (state == ST_APPLIED) && cmd_save;
    assign irq_event[IRQ_TIMEOUT] = timed_out && !cmd_abort;
    assign irq_event[IRQ_EXITED]  = session && (state != ST_ABORT) && cmd_exit;

    // Set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
        end else if (wr_en && paddr == ADDR_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~pwdata[IRQ_BITS-1:0]) | irq_event;
        end else begin
            irq_stat <= irq_stat | irq_event;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= '0;
        end else if (wr_en && paddr == ADDR_IRQ_MASK) begin
            irq_mask <= pwdata[IRQ_BITS-1:0];
        end
    end

    assign timeout_err = irq_stat[IRQ_TIMEOUT];
    assign irq = |(irq_stat & irq_mask);

    // ************************************************************
    // Read data
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == ADDR_STATUS) begin
                prdata <= {16'h0000, measured_freq[10:0], saved, timeout_err,
                           state == ST_PENDING, motor_running, session};
            end else if (paddr == ADDR_SET_FREQ) begin
                prdata <= {16'h0000, setting_freq};
            end else if (paddr == ADDR_ACT_FREQ) begin
                prdata <= {16'h0000, applied_freq};
            end else if (paddr == ADDR_FREQ_A) begin
                prdata <= {16'h0000, freq_a};
            end else if (paddr == ADDR_FREQ_B) begin
                prdata <= {16'h0000, freq_b};
            end else if (paddr == ADDR_MF_SWITCH) begin
                prdata <= {16'h0000, mf_switch};
            end else if (paddr == ADDR_MF_GAIN) begin
                prdata <= {16'h0000, mf_gain};
            end else if (paddr == ADDR_MF_COMP) begin
                prdata <= {16'h0000, mf_comp};
            end else if (paddr == ADDR_MF_BIAS_R) begin
                prdata <= {16'h0000, mf_bias_rev};
            end else if (paddr == ADDR_SUP2_FREQ) begin
                prdata <= {16'h0000, sup2_freq};
            end else if (paddr == ADDR_SUP2_COMP) begin
                prdata <= {16'h0000, sup2_comp};
            end else if (paddr == ADDR_IRQ_STAT) begin
                prdata <= {28'h0000000, irq_stat};
            end else if (paddr == ADDR_IRQ_MASK) begin
                prdata <= {28'h0000000, irq_mask};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

endmodule : vibration_suppression_setting_ctrl

// ---- verification/vib_sup_chk.sv ----
// Purpose: Port-level assertions for the suppression session block
// Assumes: One clock pclk, reset presetn asynchronous active low
// Notes:   Bound from the testbench top file
`timescale 1ns/10ps

module vib_sup_chk
    import vib_sup_pkg::*;
#(
    parameter int unsigned TIMEOUT_COUNT = 50,
    parameter int unsigned BLINK_COUNT   = 20
) (
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [7:0]                paddr,
    input wire logic [31:0]               pwdata,
    input wire logic [31:0]               prdata,
    input wire logic                      pready,
    input wire logic                      pslverr,
    input wire logic                      motor_running,
    input wire logic                      reference_present,
    input wire logic [15:0]               measured_freq,
    input wire vib_sup_pkg::display_type  display,
    input wire vib_sup_pkg::loop_cfg_type loop_cfg,
    input wire logic                      irq
);
    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic        mf_write;
    int unsigned blink_cnt;

    assign mf_write = psel && penable && pwrite && !motor_running && paddr == ADDR_MF_SWITCH;

    // Counter keeps the long blink bound out of a repetition
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt <= 0;
        end else begin
            blink_cnt <= display.done_blink ? blink_cnt + 1 : 0;
        end
    end

    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_err_access: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    chk_ffgain_off: assert property (!loop_cfg.feedforward_gain_enable)
        else $error("feedforward gain enabled");
    chk_ff_pair: assert property (loop_cfg.speed_ff_enable == loop_cfg.torque_ff_enable)
        else $error("speed and torque feedforward differ");
    chk_ff_switch: assert property (
        mf_write && pwdata[15:12] == MF_COMBINE |-> ##[1:2] loop_cfg.speed_ff_enable)
        else $error("combine digit not honoured");
    chk_run_freeze: assert property (
        motor_running && $past(motor_running) |-> $stable(loop_cfg.active_freq))
        else $error("active frequency changed while motor runs");
    chk_rest_apply: assert property (
        $changed(loop_cfg.active_freq) |-> !$past(motor_running) && !$past(reference_present))
        else $error("active frequency changed away from rest");
    chk_menu_session: assert property (display.display_menu |-> !display.session_active)
        else $error("menu shown inside session");
    chk_blink_bound: assert property (blink_cnt <= BLINK_COUNT + 2)
        else $error("done blink too long");

    cov_apply: cover property ($changed(loop_cfg.active_freq));
    cov_blink: cover property ($rose(display.done_blink));
    cov_error: cover property (pslverr);
endmodule : vib_sup_chk

// ---- verification/motor_model.sv ----
// Purpose: Servo loop stand-in reporting motion status
// Assumes: run_req from the bench starts and stops a move
// Notes:   Motor coasts STOP_DELAY cycles after the reference ends
`timescale 1ns/10ps

module motor_model #(
    parameter int unsigned STOP_DELAY = 4,
    parameter logic [15:0] VIB_FREQ   = 16'h0068
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        run_req,
    output logic             motor_running,
    output logic             reference_present,
    output logic [15:0]      measured_freq
);
    // ************************************************************
    // Motion
    // ************************************************************
    int unsigned coast;

    assign reference_present = run_req;
    assign motor_running     = run_req || coast != 0;
    // No vibration is measured at rest, so the reading drops to zero
    assign measured_freq     = motor_running ? VIB_FREQ : 16'h0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coast <= 0;
        end else begin
            coast <= run_req ? STOP_DELAY : (coast != 0 ? coast - 1 : 0);
        end
    end
endmodule : motor_model

// ---- verification/testbench.sv ----
// Purpose: Self-checking bench for the suppression session block
// Assumes: Zero-wait APB slave, shortened timeout and blink counts
// Notes:   Motor model stands in for the servo loop
`timescale 1ns/10ps

module testbench;
    import vib_sup_pkg::*;
    // ************************************************************
    // Stimulus and checks
    // ************************************************************
    localparam int unsigned TMO = 50;
    localparam int unsigned BLK = 20;

    logic         pclk = 1'b0;
    logic         presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run_req = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0, prdata, q;
    logic         pready, pslverr, motor_running, reference_present, irq, e;
    logic [15:0]  measured_freq;
    display_type  display;
    loop_cfg_type loop_cfg;
    int           fails = 0;
    int           compares = 0;

    always #2.5 pclk = ~pclk;

    vibration_suppression_setting_ctrl #(.TIMEOUT_COUNT(TMO), .BLINK_COUNT(BLK))
        vibration_suppression_setting_ctrl_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .motor_running(motor_running), .reference_present(reference_present),
        .measured_freq(measured_freq), .display(display), .loop_cfg(loop_cfg), .irq(irq));

    motor_model motor_model_inst (.pclk(pclk), .presetn(presetn), .run_req(run_req),
        .motor_running(motor_running), .reference_present(reference_present),
        .measured_freq(measured_freq));

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    task automatic check(input string n, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x) begin
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
            fails++;
        end
    endtask : check

    // One transfer; request held until pready is seen high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0);
        check(n, x, q);
    endtask : rd

    task automatic wait_irq(input int unsigned n);
        repeat (n) if (irq !== 1'b1) @(posedge pclk);
        check("irq_wait", 32'h1, 32'(irq));
    endtask : wait_irq

    task automatic final_report;
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        #(5 * 4000);
        fails++;
        final_report();
    end

    initial begin
        tick(5);
        presetn <= 1'b1;
        tick(2);
        check("ff_paths", 32'h0, 32'(loop_cfg[2:0]));
        bus(1'b0, 8'h40, 32'h0);
        check("unmapped_err", 32'h1, 32'(e));
        wr(ADDR_IRQ_MASK, 32'h0000000F);
        wr(ADDR_MF_SWITCH, 32'h00001000);
        tick(2);
        check("ff_combine", 32'h3, 32'(loop_cfg[2:1]));
        wr(ADDR_MF_SWITCH, 32'h0);
        tick(2);
        check("ff_exclude", 32'h0, 32'(loop_cfg[2:1]));
        wr(ADDR_CTRL, 32'h1 << CMD_ENTER);
        rd("shown_freq", ADDR_SET_FREQ, 32'(FREQ_A_RESET));
        wr(ADDR_MF_GAIN, 32'h0123);
        rd("locked_gain", ADDR_MF_GAIN, 32'(MF_GAIN_RESET));
        wr(ADDR_MF_SWITCH, 32'h00001000);
        rd("open_switch", ADDR_MF_SWITCH, 32'h00001000);
        wr(ADDR_MF_SWITCH, 32'h0);
        wr(ADDR_SET_FREQ, 32'h0300);
        tick(2);
        check("label_blink", 32'h2, 32'({display.setting_blink, loop_cfg[19]}));
        run_req <= 1'b1;
        tick(3);
        wr(ADDR_CTRL, 32'h1 << CMD_CONFIRM);
        tick(8);
        check("held_running", 32'({1'b1, FREQ_A_RESET}), 32'(loop_cfg[19:3]));
        run_req <= 1'b0;
        wait_irq(40);
        check("applied_freq", 32'h10300, 32'(loop_cfg[19:3]));
        check("label_steady", 32'h0, 32'(display.setting_blink));
        rd("applied_irq", ADDR_IRQ_STAT, 32'h1 << IRQ_APPLIED);
        wr(ADDR_IRQ_STAT, 32'hF);
        rd("irq_cleared", ADDR_IRQ_STAT, 32'h0);
        wr(ADDR_CTRL, 32'h1 << CMD_SAVE);
        tick(2);
        check("done_blink", 32'h1, 32'(display.done_blink));
        rd("saved_a", ADDR_FREQ_A, 32'h0300);
        rd("saved_b", ADDR_FREQ_B, 32'h0300);
        tick(BLK + 4);
        check("blink_end", 32'h2, 32'({display.display_run, display.done_blink}));
        wr(ADDR_IRQ_MASK, 32'h0);
        tick(1);
        check("irq_masked", 32'h0, 32'(irq));
        rd("saved_irq", ADDR_IRQ_STAT, 32'h1 << IRQ_SAVED);
        wr(ADDR_IRQ_STAT, 32'hF);
        wr(ADDR_IRQ_MASK, 32'hF);
        wr(ADDR_CTRL, 32'h1 << CMD_EXIT);
        tick(2);
        check("menu_shown", 32'h2, 32'({display.display_menu, display.session_active}));
        rd("exit_irq", ADDR_IRQ_STAT, 32'h1 << IRQ_EXITED);
        wr(ADDR_IRQ_STAT, 32'hF);
        wr(ADDR_CTRL, 32'h1 << CMD_ENTER);
        run_req <= 1'b1;
        wr(ADDR_STATUS, 32'h0);
        rd("copy_measured", ADDR_SET_FREQ, 32'h0068);
        wr(ADDR_SET_FREQ, 32'h0456);
        wr(ADDR_CTRL, 32'h1 << CMD_CONFIRM);
        wait_irq(TMO + 20);
        rd("timeout_irq", ADDR_IRQ_STAT, 32'h1 << IRQ_TIMEOUT);
        check("prior_kept", 32'h0300, 32'(loop_cfg.active_freq));
        wr(ADDR_IRQ_STAT, 32'hF);
        wr(ADDR_CTRL, 32'h1 << CMD_CONFIRM);
        wr(ADDR_CTRL, 32'h1 << CMD_ABORT);
        tick(4);
        run_req <= 1'b0;
        tick(20);
        check("abort_revert", 32'h0300, 32'(loop_cfg.active_freq));
        check("abort_idle", 32'h1, 32'(display.display_menu));
        final_report();
    end
endmodule : testbench

bind vibration_suppression_setting_ctrl vib_sup_chk #(
    .TIMEOUT_COUNT(TIMEOUT_COUNT), .BLINK_COUNT(BLINK_COUNT)) vib_sup_chk_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motor_running(motor_running), .reference_present(reference_present),
    .measured_freq(measured_freq), .display(display), .loop_cfg(loop_cfg), .irq(irq));
